/* File: include/sxs_pkg.sv */
// Package with constants and types for the subtract, xor, swap and sleep executor.
package sxs_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int RADDR_W = 8;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIR_A = 8'h08;
  localparam logic [7:0] OFS_DIR_B = 8'h0C;
  localparam logic [7:0] OFS_DIR_C = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;

  // ==========================================================================
  // Status field positions
  // ==========================================================================
  localparam int ST_CARRY_BIT = 0;
  localparam int ST_NIBBLE_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_EXPIRY_BIT = 4;

  // Control field positions.
  localparam int CTRL_WAKE_BIT = 0;
  localparam int CTRL_ASLEEP_BIT = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_NIBBLE = 1'b0;
  localparam logic RST_ZERO = 1'b0;
  localparam logic RST_SLEEP_FLAG = 1'b1;
  localparam logic RST_EXPIRY_FLAG = 1'b1;

  // Direction-load operand codes.
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SLEEP = 3'h1,
    OP_SUB = 3'h2,
    OP_SUB_BORROW = 3'h3,
    OP_NIBBLE_EXCHANGE = 3'h4,
    OP_XOR_IMMEDIATE = 3'h5,
    OP_XOR_FILE = 3'h6,
    OP_DIRECTION_LOAD = 3'h7
  } sxs_op_t;

  typedef enum logic [1:0] {
    RUN = 2'b00,
    ASLEEP = 2'b01,
    WAKING = 2'b11
  } sxs_state_t;

  typedef struct packed {
    sxs_op_t op;
    logic [FADDR_W-1:0] faddr;
    logic dest;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] fdata;
  } sxs_instr_t;

  typedef struct packed {
    logic valid;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sxs_fwrite_t;

  typedef struct packed {
    logic expiry_flag;
    logic sleep_entry_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } sxs_status_t;

endpackage

/* File: core/sxs_exec.sv */
// Executor for sleep, subtract, nibble exchange, xor and direction-load instructions.
//
// Notes on behaviour
// - Sleep halts execution and stops oscillator.
// - Sleep clears sleep flag, sets expiry flag.
// - Sleep clears watchdog count and prescaler.
// - Subtract: file minus accumulator, update flags.
// - Subtract with borrow uses inverted carry.
// - Destination 0 accumulator, 1 file register.
// - Nibble exchange swaps halves, flags unchanged.
// - Xor immediate into accumulator, zero only.
// - Xor file to destination, zero only.
// - Direction load: 5 A, 6 B, 7 C.
`timescale 1ns/1ps
`default_nettype none

module sxs_exec #(
  parameter int DIR_W = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Instruction issue from decode.
  input wire logic issue_valid,
  input wire sxs_pkg::sxs_instr_t issue,
  // Wake request pin.
  input wire logic wake_pin,
  // Register port.
  input wire logic [sxs_pkg::RADDR_W-1:0] reg_addr,
  input wire logic [sxs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sxs_pkg::DATA_W-1:0] reg_rdata,
  // Datapath results.
  output logic [sxs_pkg::DATA_W-1:0] acc,
  output sxs_pkg::sxs_fwrite_t file_write,
  output sxs_pkg::sxs_status_t status,
  output logic [DIR_W-1:0] port_a_direction,
  output logic [DIR_W-1:0] port_b_direction,
  output logic [DIR_W-1:0] port_c_direction,
  // Power control.
  output logic watchdog_clear,
  output logic osc_run,
  output logic asleep
);
  import sxs_pkg::*;

  // ==========================================================================
  // Arithmetic helpers
  // ==========================================================================
  // Returns {carry, nibble carry, result} of f + ~w + cin.
  // Carry out high means no borrow was taken.
  function automatic logic [DATA_W+1:0] sub_fn(
    input logic [DATA_W-1:0] f,
    input logic [DATA_W-1:0] w,
    input logic cin
  );
    logic [DATA_W:0] full;
    logic [4:0] low;
    full = {1'b0, f} + {1'b0, ~w} + {{DATA_W{1'b0}}, cin};
    low = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + {4'h0, cin};
    sub_fn = {full[DATA_W], low[4], full[DATA_W-1:0]};
  endfunction

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == '0);
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  sxs_state_t state_ff;
  sxs_state_t nxt_state;
  logic [DATA_W-1:0] acc_ff;
  sxs_fwrite_t fwr_ff;
  sxs_status_t stat_ff;
  logic [DIR_W-1:0] dir_a_ff;
  logic [DIR_W-1:0] dir_b_ff;
  logic [DIR_W-1:0] dir_c_ff;
  logic wdt_clr_ff;
  logic osc_run_ff;
  logic asleep_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic wake_meta_ff;
  logic wake_sync_ff;

  // ==========================================================================
  // Execute decode
  // ==========================================================================
  logic exec;
  logic [DATA_W+1:0] sub_res;
  logic [DATA_W-1:0] result;
  logic res_valid;
  logic upd_carry;
  logic upd_zero;
  logic sw_wake;

  assign exec = issue_valid && (state_ff == RUN);
  assign sw_wake = reg_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_WAKE_BIT];

  always_comb begin
    // Borrow input is the inverted carry; plain subtract has no borrow in.
    if (issue.op == OP_SUB_BORROW) begin
      sub_res = sub_fn(issue.fdata, acc_ff, stat_ff.carry);
    end else begin
      sub_res = sub_fn(issue.fdata, acc_ff, 1'b1);
    end
  end

  always_comb begin
    result = '0;
    res_valid = 1'b0;
    upd_carry = 1'b0;
    upd_zero = 1'b0;
    case (issue.op)
      OP_SUB, OP_SUB_BORROW: begin
        result = sub_res[DATA_W-1:0];
        res_valid = 1'b1;
        upd_carry = 1'b1;
        upd_zero = 1'b1;
      end
      OP_NIBBLE_EXCHANGE: begin
        result = {issue.fdata[3:0], issue.fdata[7:4]};
        res_valid = 1'b1;
      end
      OP_XOR_IMMEDIATE: begin
        result = acc_ff ^ issue.literal;
        res_valid = 1'b1;
        upd_zero = 1'b1;
      end
      OP_XOR_FILE: begin
        result = acc_ff ^ issue.fdata;
        res_valid = 1'b1;
        upd_zero = 1'b1;
      end
      default: begin
        result = '0;
      end
    endcase
  end

  // Results go to the file register only for file operations with destination 1.
  logic to_file;
  logic to_acc;
  assign to_file = exec && res_valid && issue.dest && (issue.op != OP_XOR_IMMEDIATE);
  assign to_acc = exec && res_valid && !to_file;

  // ==========================================================================
  // Power state machine
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RUN: begin
        if (exec && issue.op == OP_SLEEP) begin
          nxt_state = ASLEEP;
        end
      end
      ASLEEP: begin
        if (wake_sync_ff || sw_wake) begin
          nxt_state = WAKING;
        end
      end
      WAKING: begin
        nxt_state = RUN;
      end
      default: begin
        nxt_state = RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The oscillator is stopped while asleep and restarted on the wake edge.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_run_ff <= 1'b1;
      asleep_ff <= 1'b0;
    end else begin
      osc_run_ff <= (nxt_state != ASLEEP);
      asleep_ff <= (nxt_state != RUN);
    end
  end

  // One-cycle pulse that clears the watchdog count and its prescaler.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdt_clr_ff <= 1'b0;
    end else begin
      wdt_clr_ff <= exec && (issue.op == OP_SLEEP);
    end
  end

  // Wake pin synchroniser.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_meta_ff <= 1'b0;
      wake_sync_ff <= 1'b0;
    end else begin
      wake_meta_ff <= wake_pin;
      wake_sync_ff <= wake_meta_ff;
    end
  end

  // ==========================================================================
  // Accumulator
  // ==========================================================================
  // An instruction result wins over a software write in the same cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_ff <= RST_ACC;
    end else if (to_acc) begin
      acc_ff <= result;
    end else if (reg_wr && reg_addr == OFS_ACC) begin
      acc_ff <= reg_wdata;
    end
  end

  // ==========================================================================
  // File register write-back
  // ==========================================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fwr_ff <= '0;
    end else begin
      fwr_ff.valid <= to_file;
      fwr_ff.addr <= issue.faddr;
      fwr_ff.data <= result;
    end
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  // Hardware updates win over a software write to the status register.
  // Sleep and expiry flags are read-only to software; other units reset them.
  // One process owns the whole status word so that it has a single driver.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat_ff.carry <= RST_CARRY;
      stat_ff.nibble_carry_flag <= RST_NIBBLE;
      stat_ff.zero <= RST_ZERO;
      stat_ff.sleep_entry_flag <= RST_SLEEP_FLAG;
      stat_ff.expiry_flag <= RST_EXPIRY_FLAG;
    end else begin
      if (exec && (upd_carry || upd_zero)) begin
        if (upd_carry) begin
          stat_ff.carry <= sub_res[DATA_W+1];
          stat_ff.nibble_carry_flag <= sub_res[DATA_W];
        end
        stat_ff.zero <= is_zero(result);
      end else if (reg_wr && reg_addr == OFS_STATUS) begin
        stat_ff.carry <= reg_wdata[ST_CARRY_BIT];
        stat_ff.nibble_carry_flag <= reg_wdata[ST_NIBBLE_BIT];
        stat_ff.zero <= reg_wdata[ST_ZERO_BIT];
      end
      if (exec && issue.op == OP_SLEEP) begin
        stat_ff.sleep_entry_flag <= 1'b0;
        stat_ff.expiry_flag <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Port direction registers
  // ==========================================================================
  logic dir_ld;
  assign dir_ld = exec && (issue.op == OP_DIRECTION_LOAD);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dir_a_ff <= RST_DIR[DIR_W-1:0];
    end else if (dir_ld && issue.faddr == DIR_SEL_A) begin
      dir_a_ff <= acc_ff[DIR_W-1:0];
    end else if (reg_wr && reg_addr == OFS_DIR_A) begin
      dir_a_ff <= reg_wdata[DIR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dir_b_ff <= RST_DIR[DIR_W-1:0];
    end else if (dir_ld && issue.faddr == DIR_SEL_B) begin
      dir_b_ff <= acc_ff[DIR_W-1:0];
    end else if (reg_wr && reg_addr == OFS_DIR_B) begin
      dir_b_ff <= reg_wdata[DIR_W-1:0];
    end
  end

  // Operands other than the three codes match no register above.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dir_c_ff <= RST_DIR[DIR_W-1:0];
    end else if (dir_ld && issue.faddr == DIR_SEL_C) begin
      dir_c_ff <= acc_ff[DIR_W-1:0];
    end else if (reg_wr && reg_addr == OFS_DIR_C) begin
      dir_c_ff <= reg_wdata[DIR_W-1:0];
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      OFS_ACC: rd_mux = acc_ff;
      OFS_STATUS: begin
        rd_mux[ST_CARRY_BIT] = stat_ff.carry;
        rd_mux[ST_NIBBLE_BIT] = stat_ff.nibble_carry_flag;
        rd_mux[ST_ZERO_BIT] = stat_ff.zero;
        rd_mux[ST_SLEEP_BIT] = stat_ff.sleep_entry_flag;
        rd_mux[ST_EXPIRY_BIT] = stat_ff.expiry_flag;
      end
      OFS_DIR_A: rd_mux[DIR_W-1:0] = dir_a_ff;
      OFS_DIR_B: rd_mux[DIR_W-1:0] = dir_b_ff;
      OFS_DIR_C: rd_mux[DIR_W-1:0] = dir_c_ff;
      OFS_CTRL: rd_mux[CTRL_ASLEEP_BIT] = asleep_ff;
      default: rd_mux = '0;
    endcase
  end

  // Read data stand for the one cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= '0;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata = rdata_ff;
  assign acc = acc_ff;
  assign file_write = fwr_ff;
  assign status = stat_ff;
  assign port_a_direction = dir_a_ff;
  assign port_b_direction = dir_b_ff;
  assign port_c_direction = dir_c_ff;
  assign watchdog_clear = wdt_clr_ff;
  assign osc_run = osc_run_ff;
  assign asleep = asleep_ff;

endmodule // sxs_exec

`default_nettype wire

/* File: tb/sxs_exec_checker.sv */
// Assertion checker for the subtract, xor, swap and sleep executor.
`timescale 1ns/1ps
`default_nettype none
module sxs_exec_checker #(
  parameter int DIR_W = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Instruction issue and register writes.
  input wire logic issue_valid,
  input wire sxs_pkg::sxs_instr_t issue,
  input wire logic reg_wr,
  // Results.
  input wire logic [sxs_pkg::DATA_W-1:0] acc,
  input wire sxs_pkg::sxs_fwrite_t file_write,
  input wire sxs_pkg::sxs_status_t status,
  input wire logic [DIR_W-1:0] port_a_direction,
  input wire logic [DIR_W-1:0] port_b_direction,
  input wire logic [DIR_W-1:0] port_c_direction,
  input wire logic watchdog_clear,
  input wire logic osc_run,
  input wire logic asleep
);
  import sxs_pkg::*;
  logic take, sleep_take, cin;
  logic [8:0] dif;
  logic [4:0] nib;
  logic [7:0] sres, swp, ximm, xf;
  logic scar, snib;
  logic [6:0] fa;
  assign take = issue_valid && !asleep;
  assign sleep_take = take && issue.op == OP_SLEEP;
  assign cin = (issue.op == OP_SUB) | status.carry;
  assign dif = {1'b0, issue.fdata} + {1'b0, ~acc} + 9'(cin);
  assign nib = {1'b0, issue.fdata[3:0]} + {1'b0, ~acc[3:0]} + 5'(cin);
  assign sres = dif[7:0];
  assign scar = dif[8];
  assign snib = nib[4];
  assign swp = {issue.fdata[3:0], issue.fdata[7:4]};
  assign ximm = acc ^ issue.literal;
  assign xf = acc ^ issue.fdata;
  assign fa = issue.faddr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Assertions
  property p_sleep_halt;
    sleep_take |=> !osc_run && asleep && watchdog_clear ##1 !watchdog_clear;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sleep did not halt");
  property p_sleep_flags;
    sleep_take |=> !status.sleep_entry_flag && status.expiry_flag;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");
  property p_wd_cause;
    watchdog_clear |-> $past(sleep_take);
  endproperty
  a_wd_cause: assert property (p_wd_cause) else $error("stray watchdog clear");
  property p_sub;
    take && (issue.op == OP_SUB || issue.op == OP_SUB_BORROW) && !issue.dest |=> acc == $past(sres)
      && status.carry == $past(scar) && status.nibble_carry_flag == $past(snib) && status.zero == (acc == 8'h00);
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  property p_swap;
    take && issue.op == OP_NIBBLE_EXCHANGE && !issue.dest |=> acc == $past(swp) && $stable(status);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");
  property p_xor_imm;
    take && issue.op == OP_XOR_IMMEDIATE |=> acc == $past(ximm) && status.zero == (acc == 8'h00)
      && $stable(status.carry) && $stable(status.nibble_carry_flag);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");
  property p_xor_file;
    take && issue.op == OP_XOR_FILE && issue.dest |=> file_write.valid && file_write.addr == $past(fa)
      && file_write.data == $past(xf) && $stable(acc);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("xor file write wrong");
  property p_dir_hit;
    take && issue.op == OP_DIRECTION_LOAD && fa == DIR_SEL_B |=> port_b_direction == DIR_W'($past(acc))
      && $stable(port_a_direction) && $stable(status);
  endproperty
  a_dir_hit: assert property (p_dir_hit) else $error("direction load wrong");
  property p_dir_miss;
    take && issue.op == OP_DIRECTION_LOAD && (fa < DIR_SEL_A || fa > DIR_SEL_C) |=> $stable(port_a_direction)
      && $stable(port_b_direction) && $stable(port_c_direction);
  endproperty
  a_dir_miss: assert property (p_dir_miss) else $error("bad operand changed a direction");
  property p_refuse;
    asleep && !reg_wr |=> $stable(acc) && !file_write.valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("executed while asleep");
endmodule // sxs_exec_checker
bind sxs_exec sxs_exec_checker #(.DIR_W(DIR_W)) chk_u (.mclk, .rstn, .issue_valid, .issue, .reg_wr, .acc,
  .file_write, .status, .port_a_direction, .port_b_direction, .port_c_direction, .watchdog_clear, .osc_run, .asleep);
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench for the subtract, xor, swap and sleep executor.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sxs_pkg::*;
  logic mclk, rstn, issue_valid, wake_pin, reg_wr, reg_rd, watchdog_clear, osc_run, asleep;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, acc, dir_a, dir_b, dir_c;
  sxs_instr_t issue;
  sxs_fwrite_t file_write;
  sxs_status_t status;
  int error_cnt = 0;
  int cmp_count = 0;
  sxs_exec dut_u (.mclk, .rstn, .issue_valid, .issue, .wake_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .acc, .file_write, .status, .port_a_direction(dir_a), .port_b_direction(dir_b),
    .port_c_direction(dir_c), .watchdog_clear, .osc_run, .asleep);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ==========================================================================
  // Bus and check tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic ex(input sxs_op_t op, input logic [6:0] fa, input logic d, input logic [7:0] k, input logic [7:0] f);
    @(posedge mclk);
    issue_valid <= 1'b1;
    issue <= '{op, fa, d, k, f};
    @(posedge mclk);
    issue_valid <= 1'b0;
    #1;
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [7:0] adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40};
    logic [7:0] val [7] = '{8'h00, 8'h18, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rd(adr[i], val[i]);
    end
    wr(8'h40, 8'hAA);
    rd(8'h40, 8'h00);
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h18);
    wr(OFS_DIR_C, 8'h5A);
    rd(OFS_DIR_C, 8'h5A);
    check("power", {osc_run, asleep}, 2'b10);
    $display("t_regs done");
  endtask
  task automatic t_sub;
    logic [7:0] f [6] = '{8'h05, 8'h05, 8'h22, 8'h10, 8'h00, 8'h80};
    logic [7:0] w [6] = '{8'h03, 8'h06, 8'h22, 8'hFF, 8'h01, 8'h7F};
    logic [8:0] s;
    logic [4:0] n;
    logic c;
    for (int k = 0; k < 12; k++) begin
      c = (k < 6) | k[0];
      wr(OFS_STATUS, {7'h00, k[0]});
      wr(OFS_ACC, w[k % 6]);
      ex((k < 6) ? OP_SUB : OP_SUB_BORROW, 7'h20, 1'b0, 8'h00, f[k % 6]);
      s = {1'b0, f[k % 6]} + {1'b0, ~w[k % 6]} + 9'(c);
      n = {1'b0, f[k % 6][3:0]} + {1'b0, ~w[k % 6][3:0]} + 5'(c);
      check("acc", acc, s[7:0]);
      check("status", status, {2'b11, s[7:0] == 8'h00, n[4], s[8]});
    end
    wr(OFS_ACC, 8'hFF);
    ex(OP_SUB, 7'h7F, 1'b1, 8'h00, 8'h10);
    check("file_write", file_write, {1'b1, 7'h7F, 8'h11});
    check("acc", acc, 8'hFF);
    @(posedge mclk);
    #1;
    check("file_write.valid", file_write.valid, 1'b0);
    $display("t_sub done");
  endtask
  task automatic t_swap;
    wr(OFS_STATUS, 8'h07);
    ex(OP_NIBBLE_EXCHANGE, 7'h01, 1'b0, 8'h00, 8'hA5);
    check("acc", acc, 8'h5A);
    check("status", status[2:0], 3'h7);
    ex(OP_NIBBLE_EXCHANGE, 7'h00, 1'b1, 8'h00, 8'h0F);
    check("file_write", file_write, {1'b1, 7'h00, 8'hF0});
    check("acc", acc, 8'h5A);
    $display("t_swap done");
  endtask
  task automatic t_xor;
    wr(OFS_STATUS, 8'h01);
    wr(OFS_ACC, 8'h3C);
    ex(OP_XOR_IMMEDIATE, 7'h00, 1'b1, 8'h3C, 8'h00);
    check("acc", acc, 8'h00);
    check("status", status[2:0], 3'b101);
    ex(OP_NONE, 7'h00, 1'b0, 8'h55, 8'h55);
    check("acc", acc, 8'h00);
    ex(OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'hFF, 8'h00);
    check("acc", acc, 8'hFF);
    check("status", status[2:0], 3'b001);
    ex(OP_XOR_FILE, 7'h15, 1'b1, 8'h00, 8'hFF);
    check("file_write", file_write, {1'b1, 7'h15, 8'h00});
    check("acc", acc, 8'hFF);
    check("status", status[2:0], 3'b101);
    ex(OP_XOR_FILE, 7'h15, 1'b0, 8'h00, 8'h0F);
    check("acc", acc, 8'hF0);
    check("status", status[2:0], 3'b001);
    $display("t_xor done");
  endtask
  task automatic t_dir;
    logic [7:0] e [3] = '{8'hFF, 8'hFF, 8'h5A};
    wr(OFS_STATUS, 8'h02);
    for (int i = 4; i < 9; i++) begin
      wr(OFS_ACC, 8'h30 + 8'(i));
      ex(OP_DIRECTION_LOAD, 7'(i), 1'b0, 8'h00, 8'h00);
      if (i >= 5 && i <= 7) e[i - 5] = 8'h30 + 8'(i);
      check("dir_a", dir_a, e[0]);
      check("dir_b", dir_b, e[1]);
      check("dir_c", dir_c, e[2]);
      check("status", status[2:0], 3'b010);
    end
    $display("t_dir done");
  endtask
  task automatic t_sleep;
    logic [7:0] a0 = 8'h38;
    for (int m = 0; m < 2; m++) begin
      ex(OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00);
      check("acc", acc, a0);
      check("watchdog_clear", watchdog_clear, 1'b1);
      check("power", {osc_run, asleep}, 2'b01);
      check("flags", status[4:3], 2'b10);
      @(posedge mclk);
      #1;
      check("watchdog_clear", watchdog_clear, 1'b0);
      ex(OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'hFF, 8'h00);
      check("acc", acc, a0);
      rd(OFS_CTRL, 8'h02);
      if (m == 0) begin
        @(posedge mclk);
        wake_pin <= 1'b1;
      end else begin
        wr(OFS_CTRL, 8'h01);
      end
      for (int i = 0; i < 10 && asleep === 1'b1; i++) begin
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
      wake_pin <= 1'b0;
      #1;
      check("power", {osc_run, asleep}, 2'b10);
      ex(OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'h0F, 8'h00);
      check("acc", acc, a0 ^ 8'h0F);
      a0 = a0 ^ 8'h0F;
    end
    $display("t_sleep done");
  endtask
  initial begin
    #200000;
    error_cnt++;
    $display("Watchdog expired");
    test_done;
  end
  initial begin
    rstn = 1'b0;
    issue_valid = 1'b0;
    issue = '0;
    wake_pin = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_regs;
    t_sub;
    t_swap;
    t_xor;
    t_dir;
    t_sleep;
    test_done;
  end
endmodule // tb
`default_nettype wire
